// ---- common/ddf_pkg.sv ----
// Purpose: Shared constants for the drive input function decoder
// Assumes: 250 MHz clk_i, classic Wishbone register access
// Notes: Function codes are the values software writes per input
package ddf_pkg;
  localparam int NUM_DI = 8;
  localparam int NUM_FN = 15;
  localparam int CODE_W = 8;
  localparam int POS_W = 32;

  // Control modes
  typedef enum logic [1:0] {
    MODE_PULSE = 2'h0,
    MODE_PATH = 2'h1,
    MODE_S = 2'h3,
    MODE_T = 2'h2
  } ddf_mode_t;

  // Function slots inside the decoded level vector
  localparam int FN_SERVO_ENABLE = 0;
  localparam int FN_ALARM_RESET = 1;
  localparam int FN_GAIN_BOOST = 2;
  localparam int FN_PULSE_CLEAR = 3;
  localparam int FN_ZERO_CLAMP = 4;
  localparam int FN_PATH_TRIGGER = 5;
  localparam int FN_TORQUE_LIMIT = 6;
  localparam int FN_POS_LATCH = 7;
  localparam int FN_POS_REBASE = 8;
  localparam int FN_PATH_SEL0 = 9;

  // Function code per slot; 0x07 and unlisted codes decode to nothing
  localparam logic [CODE_W-1:0] FN_CODE [NUM_FN] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0C, 8'h0D,
    8'h11, 8'h12, 8'h13, 8'h1A, 8'h1B, 8'h1C
  };

  // Register byte offsets
  localparam logic [7:0] REG_FUNC_BASE = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h20;
  localparam logic [7:0] REG_ZSPD = 8'h24;
  localparam logic [7:0] REG_GAIN = 8'h28;
  localparam logic [7:0] REG_TRQ = 8'h2C;
  localparam logic [7:0] REG_CLR_MASK = 8'h30;
  localparam logic [7:0] REG_STATUS = 8'h34;
  localparam logic [7:0] REG_FAULT = 8'h38;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GSEL_LSB = 4;
  localparam int CTRL_CLRM_LSB = 8;
  localparam int CTRL_TSRC_BIT = 12;
  localparam logic [1:0] GAIN_SEL_DI = 2'h1;
  localparam logic [1:0] CLR_MODE_LEVEL = 2'h0;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] ZSPD_RST = 16'h000A;
  localparam logic [15:0] GAIN_BASE_RST = 16'h0064;
  localparam logic [7:0] GAIN_RATE_RST = 8'h01;
  localparam logic [15:0] TRQ_RST = 16'h0064;
  localparam logic [7:0] CLR_MASK_RST = 8'hFF;
endpackage

// ---- logic/ddf_func_map.sv ----
// Purpose: Maps the discrete inputs onto per-function levels
// Assumes: inputs already synchronous to clk_i
// Notes: Several inputs may carry one code; their levels are ORed
`timescale 1ns/1ps
module ddf_func_map
  import ddf_pkg::*;
(
  input wire logic [NUM_DI-1:0] din_i,
  input wire logic [CODE_W-1:0] code_i [NUM_DI],
  output logic [NUM_FN-1:0] level_o
);
  genvar f;
  generate
    for (f = 0; f < NUM_FN; f++)
    begin : g_fn
      logic [NUM_DI-1:0] hit;
      always_comb
      begin
        for (int d = 0; d < NUM_DI; d++)
          hit[d] = din_i[d] && (code_i[d] == FN_CODE[f]);
      end
      assign level_o[f] = |hit;
    end
  endgenerate
endmodule

// ---- logic/ddf_edge_det.sv ----
// Purpose: Rising-edge detector for each decoded function level
// Assumes: synchronous active-high reset
// Notes: One pulse per inactive-to-active transition
`timescale 1ns/1ps
module ddf_edge_det
  import ddf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NUM_FN-1:0] level_i,
  output logic [NUM_FN-1:0] rise_o
);
  logic [NUM_FN-1:0] prev_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_ff <= '0;
    else
      prev_ff <= level_i;
  end

  assign rise_o = level_i & ~prev_ff;
endmodule

// ---- logic/ddf_decoder.sv ----
// Purpose: Decodes discrete drive inputs into internal drive actions
// Assumes: classic Wishbone slave, 250 MHz clk_i, synchronous inputs
// Notes: All outputs are registered; registers answer one cycle late
//
// How it works
// - Code 0x01 level enables the drive in every mode; release disables.
// - Code 0x02 rising edge clears only clearable faults; others stay latched.
// - Code 0x03 level in pulse, path, speed modes multiplies gain if select 1.
// - Code 0x04 runs clear mode in pulse mode; mode 0 clears while held.
// - Code 0x05 level in speed mode locks position below speed threshold.
// - Code 0x08 rising edge in path mode starts path chosen by sampled bits.
// - Code 0x09 level outside torque mode applies torque limit, else none.
// - Code 0x0C level holds position, ignoring analog command changes.
// - Releasing the latch moves to the present analog command position.
// - Code 0x0D rising edge holds position and rebases coordinates to analog.
// - Six path-select inputs decode into one of 64 path indices.
`timescale 1ns/1ps
module ddf_decoder
  import ddf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_DI-1:0] din_i,
  input wire logic [7:0] fault_set_i,
  input wire logic [15:0] motor_speed_i,
  input wire logic [15:0] analog_pos_i,
  input wire logic [15:0] analog_trq_i,
  output logic servo_enable_o,
  output logic [7:0] fault_o,
  output logic [23:0] active_gain_o,
  output logic pulse_count_clear_o,
  output logic zero_clamp_o,
  output logic path_start_o,
  output logic [5:0] path_index_o,
  output logic torque_limit_en_o,
  output logic [15:0] torque_limit_o,
  output logic [POS_W-1:0] position_cmd_o
);
  logic [CODE_W-1:0] func_code_ff [NUM_DI];
  logic [31:0] ctrl_ff;
  logic [15:0] zspd_ff;
  logic [15:0] gain_base_ff;
  logic [7:0] gain_rate_ff;
  logic [15:0] trq_param_ff;
  logic [7:0] clr_mask_ff;
  logic [NUM_FN-1:0] lvl;
  logic [NUM_FN-1:0] rise;
  logic [5:0] path_sel;
  ddf_mode_t mode;
  logic [1:0] gain_sel;
  logic [1:0] clr_mode;
  logic pos_modes;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wmask;
  logic [31:0] status;
  logic [POS_W-1:0] analog_ext;
  logic [POS_W-1:0] offset_ff;
  logic rebase_hold_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic servo_ff;
  logic [7:0] fault_ff;
  logic [23:0] gain_ff;
  logic gain_up_ff;
  logic clr_ff;
  logic clamp_ff;
  logic start_ff;
  logic [5:0] index_ff;
  logic trq_en_ff;
  logic [15:0] trq_ff;
  logic [POS_W-1:0] pos_ff;

  ddf_func_map u_map (
    .din_i(din_i),
    .code_i(func_code_ff),
    .level_o(lvl)
  );

  ddf_edge_det u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(lvl),
    .rise_o(rise)
  );

  assign mode = ddf_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);
  assign gain_sel = ctrl_ff[CTRL_GSEL_LSB +: 2];
  assign clr_mode = ctrl_ff[CTRL_CLRM_LSB +: 2];
  assign pos_modes = (mode != MODE_T);
  assign path_sel = lvl[FN_PATH_SEL0 +: 6];
  assign analog_ext = {{(POS_W-16){analog_pos_i[15]}}, analog_pos_i};

  // Register bus
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr = wb_req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign status = {4'h0, rebase_hold_ff, index_ff, trq_en_ff,
                   clamp_ff, clr_ff, gain_up_ff, servo_ff, 8'h00,
                   lvl[7:0]};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_ff <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
      if (wb_adr_i < REG_CTRL && wb_adr_i[1:0] == 2'h0)
        rdat_ff <= {24'h000000, func_code_ff[wb_adr_i[4:2]]};
      else
        case (wb_adr_i)
          REG_CTRL: rdat_ff <= ctrl_ff;
          REG_ZSPD: rdat_ff <= {16'h0000, zspd_ff};
          REG_GAIN: rdat_ff <= {8'h00, gain_rate_ff, gain_base_ff};
          REG_TRQ: rdat_ff <= {16'h0000, trq_param_ff};
          REG_CLR_MASK: rdat_ff <= {24'h000000, clr_mask_ff};
          REG_STATUS: rdat_ff <= status;
          REG_FAULT: rdat_ff <= {24'h000000, fault_ff};
          default: rdat_ff <= 32'h0000_0000;
        endcase
    end
  end

  genvar d;
  generate
    for (d = 0; d < NUM_DI; d++)
    begin : g_code
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          func_code_ff[d] <= 8'h00;
        else if (wb_wr && wb_sel_i[0] && wb_adr_i == REG_FUNC_BASE + 8'(4*d))
          func_code_ff[d] <= wb_dat_i[7:0];
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= CTRL_RST;
      zspd_ff <= ZSPD_RST;
      gain_base_ff <= GAIN_BASE_RST;
      gain_rate_ff <= GAIN_RATE_RST;
      trq_param_ff <= TRQ_RST;
      clr_mask_ff <= CLR_MASK_RST;
    end
    else if (wb_wr)
    begin
      case (wb_adr_i)
        REG_CTRL: ctrl_ff <= (ctrl_ff & ~wmask) | (wb_dat_i & wmask);
        REG_ZSPD:
          zspd_ff <= (zspd_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        REG_GAIN:
        begin
          gain_base_ff <= (gain_base_ff & ~wmask[15:0])
                          | (wb_dat_i[15:0] & wmask[15:0]);
          if (wb_sel_i[2])
            gain_rate_ff <= wb_dat_i[23:16];
        end
        REG_TRQ:
          trq_param_ff <= (trq_param_ff & ~wmask[15:0])
                          | (wb_dat_i[15:0] & wmask[15:0]);
        REG_CLR_MASK:
          if (wb_sel_i[0])
            clr_mask_ff <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Drive actions
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      servo_ff <= 1'b0;
    else
      servo_ff <= lvl[FN_SERVO_ENABLE];
  end

  // A new fault in the clearing cycle survives the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault_ff <= 8'h00;
    else if (rise[FN_ALARM_RESET])
      fault_ff <= (fault_ff & ~clr_mask_ff) | fault_set_i;
    else
      fault_ff <= fault_ff | fault_set_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gain_up_ff <= 1'b0;
      gain_ff <= 24'h000000;
    end
    else if (lvl[FN_GAIN_BOOST] && pos_modes && gain_sel == GAIN_SEL_DI)
    begin
      gain_up_ff <= 1'b1;
      gain_ff <= gain_base_ff * gain_rate_ff;
    end
    else
    begin
      gain_up_ff <= 1'b0;
      gain_ff <= {8'h00, gain_base_ff};
    end
  end

  // Other clear modes act once per edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clr_ff <= 1'b0;
    else if (mode != MODE_PULSE)
      clr_ff <= 1'b0;
    else if (clr_mode == CLR_MODE_LEVEL)
      clr_ff <= lvl[FN_PULSE_CLEAR];
    else
      clr_ff <= rise[FN_PULSE_CLEAR];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clamp_ff <= 1'b0;
    else
      clamp_ff <= (mode == MODE_S) && lvl[FN_ZERO_CLAMP]
                  && (motor_speed_i < zspd_ff);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_ff <= 1'b0;
      index_ff <= 6'h00;
    end
    else
    begin
      start_ff <= (mode == MODE_PATH) && rise[FN_PATH_TRIGGER];
      if ((mode == MODE_PATH) && rise[FN_PATH_TRIGGER])
        index_ff <= path_sel;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trq_en_ff <= 1'b0;
      trq_ff <= 16'h0000;
    end
    else
    begin
      trq_en_ff <= pos_modes && lvl[FN_TORQUE_LIMIT];
      if (!(pos_modes && lvl[FN_TORQUE_LIMIT]))
        trq_ff <= 16'h0000;
      else if (ctrl_ff[CTRL_TSRC_BIT])
        trq_ff <= analog_trq_i;
      else
        trq_ff <= trq_param_ff;
    end
  end

  // Rebase hold runs from the edge until the input drops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rebase_hold_ff <= 1'b0;
    else if (rise[FN_POS_REBASE])
      rebase_hold_ff <= 1'b1;
    else if (!lvl[FN_POS_REBASE])
      rebase_hold_ff <= 1'b0;
  end

  // Offset tracks the analog input while held, so the motor stays put
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      offset_ff <= '0;
    else if (rise[FN_POS_REBASE] || rebase_hold_ff)
      offset_ff <= analog_ext - pos_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pos_ff <= '0;
    else if (lvl[FN_POS_LATCH] || rise[FN_POS_REBASE] || rebase_hold_ff)
      pos_ff <= pos_ff;
    else
      pos_ff <= analog_ext - offset_ff;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign servo_enable_o = servo_ff;
  assign fault_o = fault_ff;
  assign active_gain_o = gain_ff;
  assign pulse_count_clear_o = clr_ff;
  assign zero_clamp_o = clamp_ff;
  assign path_start_o = start_ff;
  assign path_index_o = index_ff;
  assign torque_limit_en_o = trq_en_ff;
  assign torque_limit_o = trq_ff;
  assign position_cmd_o = pos_ff;

  // Checks
  property p_servo;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> servo_enable_o == $past(lvl[FN_SERVO_ENABLE]);
  endproperty
  a_servo: assert property (p_servo)
    else $error("servo enable does not follow its input");

  logic [7:0] keep_faults;
  assign keep_faults = fault_ff & ~clr_mask_ff;
  property p_alarm;
    @(posedge clk_i) disable iff (rst_i)
    (rise[FN_ALARM_RESET] && !wb_wr) |=>
      fault_o == ($past(keep_faults) | $past(fault_set_i));
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm reset cleared the wrong faults");

  property p_gain;
    @(posedge clk_i) disable iff (rst_i)
    (lvl[FN_GAIN_BOOST] && pos_modes && gain_sel == GAIN_SEL_DI && !wb_wr)
      |=> gain_up_ff && active_gain_o == 24'(gain_base_ff * gain_rate_ff);
  endproperty
  a_gain: assert property (p_gain)
    else $error("boosted gain not applied");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
    (mode == MODE_PULSE && clr_mode == CLR_MODE_LEVEL
      && lvl[FN_PULSE_CLEAR]) [*2] |-> pulse_count_clear_o [*2];
  endproperty
  a_clear: assert property (p_clear)
    else $error("pulse count not held clear");

  property p_clamp;
    @(posedge clk_i) disable iff (rst_i)
    (mode != MODE_S) |=> !zero_clamp_o;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("zero clamp outside speed mode");

  sequence s_trig;
    mode == MODE_PATH && rise[FN_PATH_TRIGGER];
  endsequence
  property p_path;
    @(posedge clk_i) disable iff (rst_i)
    s_trig |=> path_start_o && path_index_o == $past(path_sel)
      ##1 !path_start_o;
  endproperty
  a_path: assert property (p_path)
    else $error("path start or index wrong");

  property p_torque;
    @(posedge clk_i) disable iff (rst_i)
    !torque_limit_en_o |-> torque_limit_o == 16'h0000;
  endproperty
  a_torque: assert property (p_torque)
    else $error("torque limit applied while disabled");

  property p_latch;
    @(posedge clk_i) disable iff (rst_i)
    lvl[FN_POS_LATCH] |=> $stable(position_cmd_o);
  endproperty
  a_latch: assert property (p_latch)
    else $error("position moved while latched");

  property p_rebase;
    @(posedge clk_i) disable iff (rst_i)
    rise[FN_POS_REBASE] ##1 !lvl[FN_POS_LATCH] |=> $stable(position_cmd_o);
  endproperty
  a_rebase: assert property (p_rebase)
    else $error("position moved after rebase");

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not a single cycle");
endmodule

// ---- bench/ddf_host_model.sv ----
// Purpose: Host controller model driving the discrete drive inputs
// Assumes: inputs change just after a rising edge of clk_i
// Notes: Path select bits sit on din 0..5, the trigger on TRIG_BIT
`timescale 1ns/1ps
module ddf_host_model
  import ddf_pkg::*;
#(
  parameter int TRIG_BIT = 6
)
(
  input wire logic clk_i,
  output logic [NUM_DI-1:0] din_o
);
  initial din_o = '0;

  task automatic drive(input logic [NUM_DI-1:0] val);
    @(posedge clk_i);
    din_o <= val;
  endtask

  // Select bits settle a full cycle before the trigger rises
  task automatic fire(input logic [5:0] idx);
    @(posedge clk_i);
    din_o <= {din_o[NUM_DI-1:6], idx};
    @(posedge clk_i);
    din_o[TRIG_BIT] <= 1'b1;
  endtask
endmodule

// ---- bench/ddf_decoder_bench.sv ----
// Purpose: Self-checking bench for the input function decoder
// Assumes: Wishbone answers one cycle after a request is taken
// Notes: Table rows cover level functions; edges are tested by hand
`timescale 1ns/1ps
module ddf_decoder_bench
  import ddf_pkg::*;
;
  typedef struct packed {
    ddf_mode_t mode;
    logic [7:0] din;
    logic [15:0] speed;
    logic [4:0] exp;
  } ddf_row_t;
  localparam logic [7:0] RATE = 8'h03;
  localparam logic [7:0] CODES_A [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
    8'h05, 8'h07, 8'h09, 8'h0C};
  localparam logic [7:0] CODES_B [8] = '{8'h11, 8'h12, 8'h13, 8'h1A,
    8'h1B, 8'h1C, 8'h08, 8'h0D};
  // Expected bits: servo, gain up, clear, clamp, torque limit
  localparam ddf_row_t ROWS [12] = '{
    '{MODE_PULSE, 8'h01, 16'h0005, 5'h10},
    '{MODE_PULSE, 8'h04, 16'h0005, 5'h08},
    '{MODE_PULSE, 8'h08, 16'h0005, 5'h04},
    '{MODE_PULSE, 8'h10, 16'h0005, 5'h00},
    '{MODE_S, 8'h10, 16'h0005, 5'h02}, '{MODE_S, 8'h10, 16'h0020, 5'h00},
    '{MODE_S, 8'h08, 16'h0005, 5'h00}, '{MODE_T, 8'h44, 16'h0005, 5'h00},
    '{MODE_PATH, 8'h44, 16'h0005, 5'h09},
    '{MODE_PULSE, 8'h20, 16'h0005, 5'h00},
    '{MODE_T, 8'h01, 16'h0005, 5'h10}, '{MODE_S, 8'h40, 16'h0005, 5'h01}};

  logic clk = 1'b0;
  logic rst;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [3:0] lanes;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic [31:0] dat_o;
  logic ack;
  logic [NUM_DI-1:0] din;
  logic [7:0] fault_set;
  logic [15:0] motor_speed;
  logic [15:0] analog_pos;
  logic [15:0] analog_trq;
  logic servo_en, clr, clamp, start, trq_en;
  logic [7:0] fault;
  logic [23:0] gain;
  logic [5:0] path_idx;
  logic [15:0] trq;
  logic [POS_W-1:0] pos;
  int failures = 0;
  int checked = 0;

  always #2 clk = ~clk;

  ddf_host_model #(.TRIG_BIT(6)) u_host (.clk_i(clk), .din_o(din));

  ddf_decoder u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .din_i(din), .fault_set_i(fault_set),
    .motor_speed_i(motor_speed), .analog_pos_i(analog_pos),
    .analog_trq_i(analog_trq), .servo_enable_o(servo_en),
    .fault_o(fault), .active_gain_o(gain), .pulse_count_clear_o(clr),
    .zero_clamp_o(clamp), .path_start_o(start), .path_index_o(path_idx),
    .torque_limit_en_o(trq_en), .torque_limit_o(trq),
    .position_cmd_o(pos));

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] adr,
    input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    wb_sel <= lanes;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    wb_rdat = dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50)
      failures++;
  endtask

  task automatic load(input logic [7:0] c [8]);
    for (int n = 0; n < NUM_DI; n++)
      wb_xfer(1'b1, REG_FUNC_BASE + 8'(4 * n), {24'h0, c[n]});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    failures++;
    end_of_test();
  end

  initial
  begin
    rst <= 1'b1;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_adr <= 8'h00;
    wb_sel <= 4'h0;
    wb_wdat <= 32'h0;
    lanes <= 4'hF;
    fault_set <= 8'h00;
    motor_speed <= 16'h0005;
    analog_pos <= 16'h0064;
    analog_trq <= 16'h1234;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk("gain_rst", gain, {8'h0, GAIN_BASE_RST});
    chk("servo_rst", servo_en, 1'b0);
    wb_xfer(1'b0, REG_ZSPD, 32'h0);
    chk("zspd_rst", wb_rdat, {16'h0, ZSPD_RST});
    wb_xfer(1'b0, REG_CLR_MASK, 32'h0);
    chk("mask_rst", wb_rdat, {24'h0, CLR_MASK_RST});
    wb_xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped", wb_rdat, 32'h0);
    $display("Test reset done");
    load(CODES_A);
    wb_xfer(1'b1, REG_GAIN, {8'h0, RATE, GAIN_BASE_RST});
    wb_xfer(1'b1, REG_CLR_MASK, 32'h0000_000F);
    foreach (ROWS[i])
    begin
      wb_xfer(1'b1, REG_CTRL, {26'h0, GAIN_SEL_DI, 2'h0, ROWS[i].mode});
      motor_speed <= ROWS[i].speed;
      u_host.drive(ROWS[i].din);
      settle(2);
      chk("servo", servo_en, ROWS[i].exp[4]);
      chk("gain", gain, ROWS[i].exp[3] ? GAIN_BASE_RST * RATE
        : {8'h0, GAIN_BASE_RST});
      chk("clear", clr, ROWS[i].exp[2]);
      chk("clamp", clamp, ROWS[i].exp[1]);
      chk("trq_en", trq_en, ROWS[i].exp[0]);
      chk("trq", trq, ROWS[i].exp[0] ? TRQ_RST : 16'h0);
    end
    $display("Test table done");
    @(posedge clk);
    fault_set <= 8'hFF;
    @(posedge clk);
    fault_set <= 8'h00;
    u_host.drive(8'h02);
    settle(2);
    chk("fault_clr", fault, 8'hF0);
    @(posedge clk);
    fault_set <= 8'h01;
    @(posedge clk);
    fault_set <= 8'h00;
    settle(2);
    chk("fault_held", fault, 8'hF1);
    u_host.drive(8'h00);
    u_host.drive(8'h02);
    settle(2);
    chk("fault_again", fault, 8'hF0);
    wb_xfer(1'b1, REG_FAULT, 32'h0);
    wb_xfer(1'b0, REG_FAULT, 32'h0);
    chk("fault_reg", wb_rdat, 32'hF0);
    $display("Test alarm reset done");
    wb_xfer(1'b1, REG_CTRL, 32'h0000_1010);
    u_host.drive(8'h40);
    settle(2);
    chk("trq_analog", trq, 16'h1234);
    @(posedge clk);
    analog_trq <= 16'h0ABC;
    settle(2);
    chk("trq_track", trq, 16'h0ABC);
    u_host.drive(8'h80);
    @(posedge clk);
    analog_pos <= 16'h00C8;
    settle(3);
    chk("pos_hold", pos, 32'h64);
    u_host.drive(8'h00);
    settle(2);
    chk("pos_follow", pos, 32'hC8);
    $display("Test latch done");
    // Edge clear mode with gain select off: one pulse, base gain kept
    wb_xfer(1'b1, REG_CTRL, 32'h0000_0100);
    u_host.drive(8'h0C);
    settle(1);
    chk("clear_edge", clr, 1'b1);
    settle(1);
    chk("clear_once", clr, 1'b0);
    chk("gain_nosel", gain, {8'h0, GAIN_BASE_RST});
    u_host.drive(8'h00);
    lanes <= 4'h3;
    wb_xfer(1'b1, REG_GAIN, {8'h0, 8'h07, GAIN_BASE_RST});
    lanes <= 4'hF;
    wb_xfer(1'b0, REG_GAIN, 32'h0);
    chk("rate_lane", wb_rdat, {8'h0, RATE, GAIN_BASE_RST});
    $display("Test clear edge done");
    load(CODES_B);
    wb_xfer(1'b1, REG_CTRL, 32'h0000_0011);
    u_host.fire(6'h2D);
    settle(1);
    chk("start", start, 1'b1);
    chk("index", path_idx, 6'h2D);
    settle(1);
    chk("start_once", start, 1'b0);
    // Index 0x2D at [26:21], trigger level at bit 5
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    chk("status", wb_rdat, 32'h05A0_0020);
    u_host.drive(8'h00);
    wb_xfer(1'b1, REG_CTRL, 32'h0000_0010);
    u_host.fire(6'h12);
    settle(1);
    chk("start_pt", start, 1'b0);
    $display("Test path trigger done");
    u_host.drive(8'h80);
    analog_pos <= 16'h01F4;
    settle(3);
    chk("rebase_hold", pos, 32'hC8);
    u_host.drive(8'h00);
    settle(3);
    chk("rebase_off", pos, 32'hC8);
    @(posedge clk);
    analog_pos <= 16'h0258;
    settle(3);
    chk("rebase_new", pos, 32'h12C);
    $display("Test rebase done");
    end_of_test();
  end
endmodule
